// ==== design/vlip_pkg.sv ====
// package: shared constants and types for the variable-length instruction parser
package vlip_pkg;
  localparam int          NUM_REGS       = 16;
  localparam logic [3:0]  SP_IDX         = 4'hE;
  localparam logic [3:0]  PC_IDX         = 4'hF;
  localparam int          MAX_SPEC       = 6;
  localparam logic [7:0]  EXT_LEAD_MIN   = 8'hFC;
  localparam logic [31:0] PC_RESET       = 32'h0000_0000;
  localparam logic [31:0] SP_RESET       = 32'h0000_0000;
  // specifier mode nibble codes
  localparam logic [3:0]  MODE_INDEX     = 4'h4;
  localparam logic [3:0]  MODE_REG       = 4'h5;
  localparam logic [3:0]  MODE_DEFER     = 4'h6;
  localparam logic [3:0]  MODE_AUTODEC   = 4'h7;
  localparam logic [3:0]  MODE_AUTOINC   = 4'h8;
  localparam logic [3:0]  MODE_AUTOINCD  = 4'h9;
  localparam logic [3:0]  MODE_BDISP     = 4'hA;
  localparam logic [3:0]  MODE_WDISP     = 4'hC;
  localparam logic [3:0]  MODE_LDISP     = 4'hE;
  // data size codes: 0 byte, 1 word, 2 long, 3 quad
  localparam logic [1:0]  SZ_BYTE        = 2'h0;
  localparam logic [1:0]  SZ_WORD        = 2'h1;
  localparam logic [1:0]  SZ_LONG        = 2'h2;
  localparam logic [1:0]  SZ_QUAD        = 2'h3;
  // access codes
  localparam logic [2:0]  ACC_READ       = 3'h0;
  localparam logic [2:0]  ACC_WRITE      = 3'h1;
  localparam logic [2:0]  ACC_MODIFY     = 3'h2;
  localparam logic [2:0]  ACC_ADDR       = 3'h3;
  localparam logic [2:0]  ACC_FIELD      = 3'h4;
  // stack push/pop/exception commands
  localparam logic [1:0]  STK_NONE       = 2'h0;
  localparam logic [1:0]  STK_PUSH       = 2'h1;
  localparam logic [1:0]  STK_POP        = 2'h2;
  localparam logic [1:0]  STK_TRAP       = 2'h3;

  typedef struct packed {
    logic [2:0] access;
    logic [1:0] size;
  } vlip_optype_t;

  typedef struct packed {
    logic [2:0]   count;
    vlip_optype_t [5:0] ops;
  } vlip_opinfo_t;

  typedef struct packed {
    logic [2:0]   index;
    logic [3:0]   mode;
    logic [3:0]   base_reg;
    logic         indexed;
    logic [3:0]   index_reg;
    logic [5:0]   literal;
    logic [31:0]  ext_data;
    logic [31:0]  eff_addr;
    logic         is_addr;
    vlip_optype_t optype;
  } vlip_operand_t;
endpackage

// ==== design/vlip_optable.sv ====
// opcode attribute lookup: operand count and per-operand type
`timescale 1ns/1ps
`default_nettype none
module vlip_optable (
  // opcode in
  input  wire logic [15:0]           OPC,
  input  wire logic                  EXT,
  // attributes out
  output vlip_pkg::vlip_opinfo_t     INFO
);
  // operand types come only from the opcode, never from specifier bytes
  always_comb begin
    INFO = '0;
    if (EXT) begin
      INFO.count = 3'h0;
    end else begin
      INFO.count = 3'(OPC[2:0] % 7);
      for (int i = 0; i < vlip_pkg::MAX_SPEC; i++) begin
        INFO.ops[i].size   = OPC[7:6];
        INFO.ops[i].access = (i == 32'(INFO.count) - 1 && OPC[3]) ? vlip_pkg::ACC_WRITE
                             : (OPC[5:4] == 2'h3 ? vlip_pkg::ACC_ADDR : vlip_pkg::ACC_READ);
      end
    end
  end
endmodule
`default_nettype wire

// ==== design/vlip_parser.sv ====
// top: instruction stream parser with general register file
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// - sixteen general registers, any operand role
// - pointer modes use register as address
// - index adds scaled index to base
// - linkage and traps use register fourteen
// - any register steps as software stack (the code never steps register fifteen)
// - push predecrements, pop postincrements
// - trap entry saves return state on stack
// - register fifteen is program counter
// - pc advances by bytes consumed
// - opcode then zero to six specifiers
// - specifier: mode, registers, extension bytes
// - operand type comes from opcode only
// - one or two byte opcodes
// - multibyte data taken low byte first
// - mode field is 2, 4 or 8 bits (the code decodes no 8-bit mode field)
module vlip_parser (
  // clock and reset
  input  wire logic                 CLK,
  input  wire logic                 RST,
  // byte stream from memory
  input  wire logic                 BYTE_VALID,
  input  wire logic [7:0]           BYTE_DATA,
  output logic                      BYTE_READY,
  output logic [31:0]               FETCH_ADDR,
  // stack commands
  input  wire logic [1:0]           STK_CMD,
  input  wire logic [31:0]          STK_DATA,
  output logic                      STK_WR,
  output logic [31:0]               STK_ADDR,
  output logic [31:0]               STK_WDATA,
  // decoded results
  output logic                      OPC_VALID,
  output logic [15:0]               OPC_CODE,
  output logic                      OPND_VALID,
  output vlip_pkg::vlip_operand_t   OPND,
  output logic                      INSN_DONE,
  output logic [3:0]                INSN_LEN
);
  typedef enum logic [2:0] {
    VL_OPC   = 3'b000,
    VL_OPC2  = 3'b001,
    VL_SPEC  = 3'b010,
    VL_IREG  = 3'b011,
    VL_EXT   = 3'b100
  } vlip_state_t;

  vlip_state_t            state_q;
  logic [31:0]            regs_q [vlip_pkg::NUM_REGS];
  logic [15:0]            opc_q;
  logic                   ext_q;
  logic [2:0]             spec_q;
  logic [1:0]             ebyte_q;
  logic [1:0]             elen_q;
  logic [3:0]             len_q;
  logic [3:0]             ireg_q;
  logic                   idx_q;
  logic [31:0]            edata_q;
  logic [3:0]             mode_q;
  logic [3:0]             rn_q;
  vlip_pkg::vlip_opinfo_t info;
  vlip_pkg::vlip_optype_t cur_t;
  logic                   take;

  vlip_optable u_optable (
    .OPC  (opc_q),
    .EXT  (ext_q),
    .INFO (info)
  );

  assign take  = BYTE_VALID && BYTE_READY;
  assign cur_t = info.ops[spec_q];

  // extension bytes needed by a mode nibble
  function automatic logic [2:0] ext_bytes(input logic [3:0] m, input logic [3:0] r, input logic [1:0] sz);
    ext_bytes = 3'h0;
    if (m == vlip_pkg::MODE_AUTOINC && r == vlip_pkg::PC_IDX)
      ext_bytes = (sz == vlip_pkg::SZ_QUAD) ? 3'h4 : 3'(1 << sz);
    else if (m == vlip_pkg::MODE_AUTOINCD && r == vlip_pkg::PC_IDX)
      ext_bytes = 3'h4;
    else if (m[3:1] == vlip_pkg::MODE_BDISP[3:1])
      ext_bytes = 3'h1;
    else if (m[3:1] == vlip_pkg::MODE_WDISP[3:1])
      ext_bytes = 3'h2;
    else if (m[3:1] == vlip_pkg::MODE_LDISP[3:1])
      ext_bytes = 3'h4;
  endfunction

  function automatic logic [31:0] step(input logic [1:0] sz);
    step = 32'h1 << sz;
  endfunction

  // parse sequencer
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_q <= VL_OPC;
      opc_q   <= 16'h0000;
      ext_q   <= 1'b0;
      spec_q  <= 3'h0;
      ebyte_q <= 2'h0;
      elen_q  <= 2'h0;
      len_q   <= 4'h0;
      ireg_q  <= 4'h0;
      idx_q   <= 1'b0;
      edata_q <= 32'h0000_0000;
      mode_q  <= 4'h0;
      rn_q    <= 4'h0;
    end else if (take) begin
      len_q <= len_q + 4'h1;
      case (state_q)
        VL_OPC: begin
          opc_q <= {8'h00, BYTE_DATA};
          len_q <= 4'h1;
          spec_q <= 3'h0;
          idx_q <= 1'b0;
          ext_q <= BYTE_DATA >= vlip_pkg::EXT_LEAD_MIN;
          if (BYTE_DATA >= vlip_pkg::EXT_LEAD_MIN)
            state_q <= VL_OPC2;
          else if (3'(BYTE_DATA[2:0] % 7) != 3'h0)
            state_q <= VL_SPEC;
          else
            state_q <= VL_OPC;
        end
        VL_OPC2: begin
          opc_q   <= {opc_q[7:0], BYTE_DATA};
          state_q <= VL_OPC;
        end
        VL_SPEC: begin
          // top two bits 00 is literal (2-bit field), 4 bits otherwise
          mode_q  <= BYTE_DATA[7:4];
          rn_q    <= BYTE_DATA[3:0];
          edata_q <= 32'h0000_0000;
          ebyte_q <= 2'h0;
          if (BYTE_DATA[7:4] == vlip_pkg::MODE_INDEX) begin
            idx_q   <= 1'b1;
            ireg_q  <= BYTE_DATA[3:0];
            state_q <= VL_IREG;
          end else if (ext_bytes(BYTE_DATA[7:4], BYTE_DATA[3:0], cur_t.size) != 3'h0) begin
            elen_q  <= 2'(ext_bytes(BYTE_DATA[7:4], BYTE_DATA[3:0], cur_t.size) - 3'h1);
            state_q <= VL_EXT;
          end else begin
            idx_q   <= 1'b0;
            spec_q  <= spec_q + 3'h1;
            state_q <= (spec_q + 3'h1 == info.count) ? VL_OPC : VL_SPEC;
          end
        end
        VL_IREG: begin
          mode_q  <= BYTE_DATA[7:4];
          rn_q    <= BYTE_DATA[3:0];
          if (ext_bytes(BYTE_DATA[7:4], BYTE_DATA[3:0], cur_t.size) != 3'h0) begin
            elen_q  <= 2'(ext_bytes(BYTE_DATA[7:4], BYTE_DATA[3:0], cur_t.size) - 3'h1);
            state_q <= VL_EXT;
          end else begin
            idx_q   <= 1'b0;
            spec_q  <= spec_q + 3'h1;
            state_q <= (spec_q + 3'h1 == info.count) ? VL_OPC : VL_SPEC;
          end
        end
        VL_EXT: begin
          // low byte arrives first
          edata_q[8*ebyte_q +: 8] <= BYTE_DATA;
          ebyte_q <= ebyte_q + 2'h1;
          if (ebyte_q == elen_q) begin
            idx_q   <= 1'b0;
            spec_q  <= spec_q + 3'h1;
            state_q <= (spec_q + 3'h1 == info.count) ? VL_OPC : VL_SPEC;
          end
        end
        default: state_q <= VL_OPC;
      endcase
    end
  end

  // operand completes when the sequencer leaves a specifier
  logic                  fin;
  logic [3:0]            f_mode;
  logic [3:0]            f_rn;
  logic [31:0]           f_ext;
  logic [31:0]           f_base;
  logic [31:0]           f_addr;
  logic                  f_isaddr;
  logic [2:0]            f_need;
  always_comb begin
    f_mode = (state_q == VL_EXT) ? mode_q : BYTE_DATA[7:4];
    f_rn   = (state_q == VL_EXT) ? rn_q : BYTE_DATA[3:0];
    f_ext  = edata_q;
    if (state_q == VL_EXT)
      f_ext[8*ebyte_q +: 8] = BYTE_DATA;
    f_need = ext_bytes(f_mode, f_rn, cur_t.size);
    fin = take && ((state_q == VL_EXT && ebyte_q == elen_q) ||
                   ((state_q == VL_SPEC || state_q == VL_IREG) && f_need == 3'h0 &&
                    !(state_q == VL_SPEC && f_mode == vlip_pkg::MODE_INDEX)));
    // pc already counts every taken byte, so plus one is the pc after this byte
    f_base   = (f_rn == vlip_pkg::PC_IDX) ? regs_q[vlip_pkg::PC_IDX] + 32'h1
                                          : regs_q[f_rn];
    f_isaddr = f_mode != vlip_pkg::MODE_REG && f_mode[3:2] != 2'h0;
    case (f_mode)
      vlip_pkg::MODE_AUTODEC: f_addr = regs_q[f_rn] - step(cur_t.size);
      vlip_pkg::MODE_DEFER, vlip_pkg::MODE_AUTOINC,
      vlip_pkg::MODE_AUTOINCD: f_addr = regs_q[f_rn];
      default: f_addr = f_base + f_ext;
    endcase
    if (f_mode[3:2] != 2'h0 && f_mode >= vlip_pkg::MODE_BDISP)
      f_addr = f_base + f_ext;
    if (idx_q)
      f_addr = f_addr + (regs_q[ireg_q] << cur_t.size);
  end

  // a stepping operand owns the register update port; a stack command then is refused whole
  logic                  stp_own;
  assign stp_own = fin && f_rn != vlip_pkg::PC_IDX &&
                   (f_mode == vlip_pkg::MODE_AUTODEC || f_mode == vlip_pkg::MODE_AUTOINC ||
                    f_mode == vlip_pkg::MODE_AUTOINCD);

  // decoded outputs, registered
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      OPND_VALID <= 1'b0;
      OPND       <= '0;
      OPC_VALID  <= 1'b0;
      OPC_CODE   <= 16'h0000;
      INSN_DONE  <= 1'b0;
      INSN_LEN   <= 4'h0;
    end else begin
      OPND_VALID <= fin;
      OPC_VALID  <= take && ((state_q == VL_OPC && BYTE_DATA < vlip_pkg::EXT_LEAD_MIN) ||
                             state_q == VL_OPC2);
      INSN_DONE  <= take && (((state_q == VL_OPC) && BYTE_DATA < vlip_pkg::EXT_LEAD_MIN &&
                              3'(BYTE_DATA[2:0] % 7) == 3'h0) || state_q == VL_OPC2 ||
                             (fin && spec_q + 3'h1 == info.count));
      INSN_LEN   <= (state_q == VL_OPC) ? 4'h1 : len_q + 4'h1;
      if (take && state_q == VL_OPC)
        OPC_CODE <= {8'h00, BYTE_DATA};
      else if (take && state_q == VL_OPC2)
        OPC_CODE <= {opc_q[7:0], BYTE_DATA};
      if (fin) begin
        OPND.index     <= spec_q;
        OPND.mode      <= f_mode;
        OPND.base_reg  <= f_rn;
        OPND.indexed   <= idx_q;
        OPND.index_reg <= ireg_q;
        OPND.literal   <= (state_q == VL_EXT) ? 6'h00 : BYTE_DATA[5:0];
        OPND.ext_data  <= f_ext;
        OPND.eff_addr  <= f_addr;
        OPND.is_addr   <= f_isaddr;
        OPND.optype    <= cur_t;
      end
    end
  end

  // register file: pc, stack and stepping pointers
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < vlip_pkg::NUM_REGS; i++)
        regs_q[i] <= 32'h0000_0000;
      regs_q[vlip_pkg::PC_IDX] <= vlip_pkg::PC_RESET;
      regs_q[vlip_pkg::SP_IDX] <= vlip_pkg::SP_RESET;
    end else begin
      if (take)
        regs_q[vlip_pkg::PC_IDX] <= regs_q[vlip_pkg::PC_IDX] + 32'h1;
      if (stp_own) begin
        if (f_mode == vlip_pkg::MODE_AUTODEC)
          regs_q[f_rn] <= regs_q[f_rn] - step(cur_t.size);
        else if (f_mode == vlip_pkg::MODE_AUTOINC)
          regs_q[f_rn] <= regs_q[f_rn] + step(cur_t.size);
        else if (f_mode == vlip_pkg::MODE_AUTOINCD)
          regs_q[f_rn] <= regs_q[f_rn] + 32'h4;
      end else if (STK_CMD == vlip_pkg::STK_PUSH || STK_CMD == vlip_pkg::STK_TRAP)
        regs_q[vlip_pkg::SP_IDX] <= regs_q[vlip_pkg::SP_IDX] - 32'h4;
      else if (STK_CMD == vlip_pkg::STK_POP)
        regs_q[vlip_pkg::SP_IDX] <= regs_q[vlip_pkg::SP_IDX] + 32'h4;
    end
  end

  // stack write port; trap saves the current value of the pc register
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      STK_WR    <= 1'b0;
      STK_ADDR  <= 32'h0000_0000;
      STK_WDATA <= 32'h0000_0000;
    end else begin
      // no store without the matching predecrement
      STK_WR    <= (STK_CMD == vlip_pkg::STK_PUSH || STK_CMD == vlip_pkg::STK_TRAP) && !stp_own;
      STK_ADDR  <= (STK_CMD == vlip_pkg::STK_POP) ? regs_q[vlip_pkg::SP_IDX]
                                                  : regs_q[vlip_pkg::SP_IDX] - 32'h4;
      STK_WDATA <= (STK_CMD == vlip_pkg::STK_TRAP) ? regs_q[vlip_pkg::PC_IDX] : STK_DATA;
    end
  end

  // fetch side; ready every cycle after reset, stack commands never stall it
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      BYTE_READY <= 1'b0;
      FETCH_ADDR <= vlip_pkg::PC_RESET;
    end else begin
      BYTE_READY <= 1'b1;
      FETCH_ADDR <= take ? regs_q[vlip_pkg::PC_IDX] + 32'h1 : regs_q[vlip_pkg::PC_IDX];
    end
  end

  a_pc_advance: assert property (@(posedge CLK) disable iff (RST)
    take |=> regs_q[vlip_pkg::PC_IDX] == $past(regs_q[vlip_pkg::PC_IDX]) + 32'h1)
    else $error("pc did not advance by one per byte");
  a_push_predec: assert property (@(posedge CLK) disable iff (RST)
    (STK_CMD == vlip_pkg::STK_PUSH && !stp_own) |=> STK_WR && STK_ADDR == regs_q[vlip_pkg::SP_IDX])
    else $error("push address not predecremented sp");
  a_trap_saves_pc: assert property (@(posedge CLK) disable iff (RST)
    (STK_CMD == vlip_pkg::STK_TRAP) |=> STK_WDATA == $past(regs_q[vlip_pkg::PC_IDX]))
    else $error("trap did not save pc");
  a_lead_ext: assert property (@(posedge CLK) disable iff (RST)
    (take && state_q == VL_OPC && BYTE_DATA >= vlip_pkg::EXT_LEAD_MIN) |=> state_q == VL_OPC2)
    else $error("lead byte did not start two-byte opcode");
  a_spec_bound: assert property (@(posedge CLK) disable iff (RST)
    spec_q <= 3'(vlip_pkg::MAX_SPEC))
    else $error("more than six specifiers");
  a_opnd_type: assert property (@(posedge CLK) disable iff (RST)
    fin |=> OPND_VALID && OPND.optype == $past(cur_t) && OPND.optype.size == $past(opc_q[7:6]))
    else $error("operand type not from opcode");
endmodule
`default_nettype wire

// ==== verification/vlip_mem_model.sv ====
// instruction memory model that feeds the parser byte stream
`timescale 1ns/1ps
`default_nettype none
module vlip_mem_model (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST,
  // byte stream
  input  wire logic        BYTE_READY,
  input  wire logic [31:0] FETCH_ADDR,
  output logic             BYTE_VALID,
  output logic [7:0]       BYTE_DATA,
  // bench control
  input  wire logic [31:0] LIMIT,
  input  wire logic        SLOW
);
  logic [7:0] mem [0:255];
  logic       ph_q;
  // an offered byte is held until it is taken; slow mode stalls every other cycle
  always @(negedge CLK) begin
    if (RST) begin
      ph_q       <= 1'b0;
      BYTE_VALID <= 1'b0;
      BYTE_DATA  <= 8'h00;
    end else begin
      ph_q <= ~ph_q;
      if (BYTE_VALID && !BYTE_READY) begin
        BYTE_VALID <= 1'b1;
      end else if (FETCH_ADDR < LIMIT && (!SLOW || ph_q)) begin
        BYTE_VALID <= 1'b1;
        BYTE_DATA  <= mem[FETCH_ADDR[7:0]];
      end else begin
        BYTE_VALID <= 1'b0;
        // idle bus inverts its value each cycle, so the last byte shows again every other idle cycle
        BYTE_DATA  <= ~BYTE_DATA;
      end
    end
  end
endmodule
`default_nettype wire

// ==== verification/vlip_parser_tb_top.sv ====
// self-checking bench for the instruction stream parser
`timescale 1ns/1ps
`default_nettype none
module vlip_parser_tb_top;
  typedef struct packed {
    logic                   lit;
    logic [1:0]             chk;
    logic [3:0]             mode;
    logic [3:0]             base;
    logic                   ix;
    logic [3:0]             ixr;
    logic [31:0]            ext;
    logic [31:0]            eff;
    logic [5:0]             litv;
    vlip_pkg::vlip_optype_t ot;
  } vlip_note_t;
  logic                    clk, rst, byte_valid, byte_ready, stk_wr, opc_valid, opnd_valid, insn_done, slow;
  logic [7:0]              byte_data;
  logic [1:0]              stk_cmd;
  logic [31:0]             stk_data, stk_addr, stk_wdata, fetch_addr, limit, sp_exp, es_hi;
  logic [15:0]             opc_code, eo;
  logic [3:0]              insn_len, el;
  vlip_pkg::vlip_operand_t opnd;
  vlip_pkg::vlip_optype_t  cur_ot;
  vlip_note_t              en;
  logic [63:0]             es;
  logic [15:0]             q_opc[$];
  logic [3:0]              q_len[$];
  vlip_note_t              q_opnd[$];
  logic [63:0]             q_stk[$];
  int                      error_cnt, n_checks, n_done, n_exp, wr, i, k, c;

  vlip_parser dut (.CLK(clk), .RST(rst), .BYTE_VALID(byte_valid), .BYTE_DATA(byte_data), .BYTE_READY(byte_ready),
    .FETCH_ADDR(fetch_addr), .STK_CMD(stk_cmd), .STK_DATA(stk_data), .STK_WR(stk_wr), .STK_ADDR(stk_addr),
    .STK_WDATA(stk_wdata), .OPC_VALID(opc_valid), .OPC_CODE(opc_code), .OPND_VALID(opnd_valid), .OPND(opnd),
    .INSN_DONE(insn_done), .INSN_LEN(insn_len));
  vlip_mem_model mdl (.CLK(clk), .RST(rst), .BYTE_READY(byte_ready), .FETCH_ADDR(fetch_addr),
    .BYTE_VALID(byte_valid), .BYTE_DATA(byte_data), .LIMIT(limit), .SLOW(slow));

  always #2.5 clk = ~clk;

  task automatic fail(input string m);
    error_cnt++;
    $display("[ERR] %0t %s", $time, m);
  endtask
  task automatic stop_test;
    if (error_cnt == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic put(input logic [7:0] b);
    mdl.mem[wr] = b;
    wr++;
  endtask
  // queue the opcode and length notes and place the opcode bytes
  task automatic insn(input logic [15:0] opc, input logic [3:0] len);
    q_opc.push_back(opc);
    q_len.push_back(len);
    n_exp++;
    cur_ot = '{vlip_pkg::ACC_READ, opc[7:6]};
    if (opc[15:8] >= vlip_pkg::EXT_LEAD_MIN) put(opc[15:8]);
    put(opc[7:0]);
  endtask
  task automatic spec(input logic [3:0] m, input logic [3:0] b, input logic [1:0] ck, input logic [31:0] x,
                      input logic [31:0] e);
    q_opnd.push_back('{1'b0, ck, m, b, 1'b0, 4'h0, x, e, 6'h00, cur_ot});
  endtask
  // release the program to the memory model and wait for every instruction
  task automatic run;
    limit = 32'(wr);
    for (k = 0; k < 4000 && n_done < n_exp; k++) @(negedge clk);
    if (n_done < n_exp) begin
      fail("timeout waiting for instructions");
      stop_test();
    end else begin
      n_checks++;
      if (fetch_addr !== 32'(wr)) fail("program counter wrong");
    end
  endtask
  task automatic stk(input logic [1:0] cm, input logic [31:0] d);
    stk_cmd = cm;
    stk_data = d;
    if (cm != vlip_pkg::STK_POP) sp_exp = sp_exp - 32'h0000_0004;
    if (cm == vlip_pkg::STK_PUSH) q_stk.push_back({sp_exp, d});
    if (cm == vlip_pkg::STK_TRAP) q_stk.push_back({sp_exp, 32'(wr)});
    if (cm == vlip_pkg::STK_POP) sp_exp = sp_exp + 32'h0000_0004;
    @(negedge clk);
  endtask

  // result watcher: each pulse takes the oldest note
  always @(negedge clk) begin
    if (!rst && opc_valid === 1'b1) begin
      eo = (q_opc.size() > 0) ? q_opc.pop_front() : 16'hXXXX;
      n_checks++;
      if (opc_code !== eo) fail("opcode mismatch");
    end
    if (!rst && insn_done === 1'b1) begin
      el = (q_len.size() > 0) ? q_len.pop_front() : 4'hX;
      n_done++;
      n_checks++;
      if (insn_len !== el) fail("length mismatch");
    end
    if (!rst && opnd_valid === 1'b1) begin
      en = (q_opnd.size() > 0) ? q_opnd.pop_front() : 'x;
      n_checks++;
      if (en.lit === 1'b1) begin
        if (opnd.literal !== en.litv) fail("literal mismatch");
      end else if (opnd.mode !== en.mode || opnd.base_reg !== en.base) fail("specifier mismatch");
      if (en.lit !== 1'b1 && opnd.indexed !== en.ix) fail("index flag mismatch");
      if (en.lit !== 1'b1 && opnd.is_addr !== (en.mode != vlip_pkg::MODE_REG)) fail("address flag mismatch");
      if (en.ix === 1'b1 && opnd.index_reg !== en.ixr) fail("index register mismatch");
      if (en.chk[0] === 1'b1 && opnd.ext_data !== en.ext) fail("extension data mismatch");
      if (en.chk[1] === 1'b1 && opnd.eff_addr !== en.eff) fail("pointer address mismatch");
      if (opnd.optype !== en.ot) fail("operand type mismatch");
    end
    if (!rst && stk_wr === 1'b1) begin
      es = (q_stk.size() > 0) ? q_stk.pop_front() : 64'hX;
      n_checks++;
      if ({stk_addr, stk_wdata} !== es) fail("stack write mismatch");
    end
  end

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    slow = 1'b0;
    limit = 32'h0;
    stk_cmd = vlip_pkg::STK_NONE;
    stk_data = 32'h0;
    sp_exp = vlip_pkg::SP_RESET;
    void'($urandom(62946));
    repeat (6) @(negedge clk);
    rst = 1'b0;
    insn(16'h0001, 4'h2);
    put(8'h55);
    spec(vlip_pkg::MODE_REG, 4'h5, 2'b00, 32'h0, 32'h0);
    insn(16'h0000, 4'h1);
    insn(16'h0041, 4'h4);
    put(8'h8F);
    put(8'h56);
    put(8'h34);
    spec(vlip_pkg::MODE_AUTOINC, vlip_pkg::PC_IDX, 2'b01, 32'h0000_3456, 32'h0);
    insn(16'h0006, 4'h7);
    for (i = 0; i < vlip_pkg::MAX_SPEC; i++) begin
      put(8'h50 | 8'(i));
      spec(vlip_pkg::MODE_REG, 4'(i), 2'b00, 32'h0, 32'h0);
    end
    for (i = 252; i < 256; i++) insn({8'(i), 8'($urandom)}, 4'h2);
    insn(16'h0001, 4'h3);
    put(8'hA1);
    put(8'h06);
    spec(vlip_pkg::MODE_BDISP, 4'h1, 2'b01, 32'h0000_0006, 32'h0);
    // byte relative on the program counter: base is the pc after the displacement
    insn(16'h0001, 4'h3);
    put(8'hAF);
    put(8'h10);
    spec(vlip_pkg::MODE_BDISP, vlip_pkg::PC_IDX, 2'b11, 32'h0000_0010, 32'(wr) + 32'h0000_0010);
    insn(16'h0001, 4'h2);
    put(8'h2A);
    spec(4'h0, 4'h0, 2'b00, 32'h0, 32'h0);
    q_opnd[$].lit = 1'b1;
    q_opnd[$].litv = 6'h2A;
    insn(16'h0001, 4'h3);
    put(8'h43);
    put(8'h61);
    spec(vlip_pkg::MODE_DEFER, 4'h1, 2'b00, 32'h0, 32'h0);
    q_opnd[$].ix = 1'b1;
    q_opnd[$].ixr = 4'h3;
    run();
    // stack commands back to back, then idle
    stk(vlip_pkg::STK_PUSH, 32'hA5A5_0001);
    stk(vlip_pkg::STK_PUSH, 32'h5A5A_0002);
    stk(vlip_pkg::STK_POP, 32'h0);
    stk(vlip_pkg::STK_TRAP, 32'h0);
    stk_cmd = vlip_pkg::STK_NONE;
    repeat (3) @(negedge clk);
    n_checks++;
    if (q_stk.size() != 0) fail("stack write missing");
    // slow memory: stepping on the hardware stack register, then random register operands
    slow = 1'b1;
    es_hi = sp_exp - 32'h0000_0004;
    insn(16'h0081, 4'h2);
    put(8'h7E);
    spec(vlip_pkg::MODE_AUTODEC, vlip_pkg::SP_IDX, 2'b10, 32'h0, es_hi);
    insn(16'h0081, 4'h2);
    put(8'h6E);
    spec(vlip_pkg::MODE_DEFER, vlip_pkg::SP_IDX, 2'b10, 32'h0, es_hi);
    for (i = 0; i < 20; i++) begin
      c = $urandom % 7;
      insn(16'h0080 | 16'(c), 4'(c + 1));
      for (k = 0; k < c; k++) begin
        el = 4'($urandom % 15);
        put(8'h50 | 8'(el));
        spec(vlip_pkg::MODE_REG, el, 2'b00, 32'h0, 32'h0);
      end
    end
    run();
    repeat (3) @(negedge clk);
    stop_test();
  end
endmodule
`default_nettype wire
